// >>> ccpc_core_model.sv
// ccpc_core_model: processor core stand-in with one wake-up source.
// assumes one clock and an active-low asynchronous reset.
`timescale 1ns/100ps
module ccpc_core_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic wfi,
  input wire logic wake,
  output logic sleeping,
  output logic wake_event
);
  // ****************************************
  // sleep and wake
  // ****************************************
  // sleep flag: set by wfi, dropped by the wake-up pulse
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sleeping <= 1'b0;
    end else if (wake_event) begin
      sleeping <= 1'b0;
    end else if (wfi) begin
      sleeping <= 1'b1;
    end
  end
  // wake-up source: one pulse per request
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wake_event <= 1'b0;
    end else begin
      wake_event <= wake;
    end
  end
endmodule // ccpc_core_model

// >>> ccpc_monitor.sv
// ccpc_monitor: port-level checks of the clock and power controller.
// assumes CLK_EN is held high and inputs change just after REF_CLK rises.
`timescale 1ns/100ps
module ccpc_monitor (
  input wire logic REF_CLK,
  input wire logic RSTN,
  input wire logic CLK_EN,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PREADY,
  input wire logic PSLVERR,
  input wire logic WAKE_EVENT,
  input wire logic TICK_USE_EXTERNAL,
  input wire logic HXT_EN,
  input wire logic HIRC_EN,
  input wire logic LXT_EN,
  input wire logic LIRC_EN,
  input wire logic PLL_EN,
  input wire logic [2:0] SYS_CLK_SEL,
  input wire logic SYS_CLK_GATE,
  input wire logic TICK_EXT_GATE,
  input wire logic [31:0] AHB_CLK_GATE,
  input wire logic POWER_DOWN
);
  // ****************************************
  // properties
  // ****************************************
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RSTN);
  AST_APB_READY: assert property (PSEL && !PENABLE && CLK_EN |=> PREADY)
    else $error("no ready after setup");
  AST_APB_ONE: assert property (PREADY |=> !PREADY)
    else $error("ready longer than one cycle");
  AST_APB_ERR: assert property (PSLVERR |-> PREADY)
    else $error("error without ready");
  AST_HS_OFF: assert property ($rose(POWER_DOWN) |-> !HXT_EN && !HIRC_EN)
    else $error("high-speed source on in power-down");
  AST_CLK_STOP: assert property ($rose(POWER_DOWN) |-> !SYS_CLK_GATE && !PLL_EN && AHB_CLK_GATE == 32'h0)
    else $error("system clocks running in power-down");
  AST_LS_KEEP: assert property (POWER_DOWN && $past(POWER_DOWN) |-> $stable(LXT_EN) && $stable(LIRC_EN))
    else $error("low-speed source changed in power-down");
  AST_STAY_DOWN: assert property (POWER_DOWN && !WAKE_EVENT && !HXT_EN && !SYS_CLK_GATE |=> POWER_DOWN)
    else $error("left power-down without wake-up");
  AST_NO_GLITCH: assert property (!$stable(SYS_CLK_SEL) |-> !SYS_CLK_GATE && !$past(SYS_CLK_GATE))
    else $error("clock select moved with gate open");
  AST_TICK: assert property (TICK_EXT_GATE |->
    $past(TICK_USE_EXTERNAL) && !(POWER_DOWN && $past(TICK_EXT_GATE)))
    else $error("tick gate open without request");
  // main scenarios reached
  COV_DOWN: cover property ($rose(POWER_DOWN));
  COV_ERR: cover property (PSLVERR);
  COV_SWITCH: cover property (!$stable(SYS_CLK_SEL));
endmodule // ccpc_monitor

bind ccpc_top ccpc_monitor mon_u (.REF_CLK, .RSTN, .CLK_EN, .PSEL, .PENABLE, .PREADY, .PSLVERR,
  .WAKE_EVENT, .TICK_USE_EXTERNAL, .HXT_EN, .HIRC_EN, .LXT_EN, .LIRC_EN, .PLL_EN,
  .SYS_CLK_SEL, .SYS_CLK_GATE, .TICK_EXT_GATE, .AHB_CLK_GATE, .POWER_DOWN);

// >>> ccpc_pkg.sv
// ccpc_pkg: register map, field positions, reset values and timing for the
// chip clock and power controller.
// assumes a 125 MHz reference clock and a 32-bit APB register bus.
package ccpc_pkg;

  // ****************************************
  // register byte offsets
  // ****************************************
  localparam logic [7:0] OFS_PWR = 8'h00;      // power_down_control
  localparam logic [7:0] OFS_AHB = 8'h04;      // ahb_clock_enable
  localparam logic [7:0] OFS_APB = 8'h08;      // apb_clock_enable
  localparam logic [7:0] OFS_STAT = 8'h0C;     // clock_status_monitor
  localparam logic [7:0] OFS_SEL0 = 8'h10;     // clock_select_0
  localparam logic [7:0] OFS_SEL1 = 8'h14;     // clock_select_1
  localparam logic [7:0] OFS_DIV = 8'h18;      // clock_divider
  localparam logic [7:0] OFS_SEL2 = 8'h1C;     // clock_select_2
  localparam logic [7:0] OFS_PLL = 8'h20;      // pll_control
  localparam logic [7:0] OFS_FRQ = 8'h24;      // frequency_divider_control
  localparam logic [7:0] OFS_APB1 = 8'h30;     // apb_clock_enable_1
  localparam logic [7:0] OFS_SEL3 = 8'h34;     // clock_select_3
  localparam logic [7:0] OFS_DIV1 = 8'h38;     // clock_divider_1
  localparam logic [7:0] OFS_LSKEEP = 8'h3C;   // low_speed_keep_mask

  // ****************************************
  // power_down_control fields
  // ****************************************
  localparam int B_HXT_EN = 0;      // high-speed crystal enable
  localparam int B_LXT_EN = 1;      // 32.768 kHz crystal enable
  localparam int B_HIRC_EN = 2;     // 22.1184 MHz oscillator enable
  localparam int B_LIRC_EN = 3;     // 10 kHz oscillator enable
  localparam int B_WU_DLY = 4;      // wake-up settle delay enable
  localparam int B_WU_IE = 5;       // wake_up_interrupt_enable
  localparam int B_WU_STS = 6;      // wake_up_status_flag
  localparam int B_PD_EN = 7;       // power_down_enable
  localparam int B_WAIT_CPU = 8;    // wait_for_processor_sleep
  localparam int PWR_W = 9;         // implemented width

  // ****************************************
  // select, pll and status fields
  // ****************************************
  localparam int SYS_SEL_LSB = 0;   // system clock select [2:0]
  localparam int TICK_SEL_LSB = 3;  // tick clock select [5:3]
  localparam int SEL_W = 3;
  localparam int B_PLL_OFF = 16;    // pll powered down
  localparam int B_PLL_REF = 19;    // pll reference: 0 crystal, 1 oscillator
  localparam int B_STAT_BUSY = 7;   // system clock switch in progress

  // ****************************************
  // reset values
  // ****************************************
  localparam logic [31:0] RST_PWR = 32'h0000_001C;
  localparam logic [31:0] RST_AHB = 32'h0000_0005;
  localparam logic [31:0] RST_APB = 32'h0000_0001;
  localparam logic [31:0] RST_SEL0 = 32'h0000_003F;
  localparam logic [31:0] RST_SEL1 = 32'hFFFF_FFFF;
  localparam logic [31:0] RST_DIV = 32'h0000_0000;
  localparam logic [31:0] RST_SEL2 = 32'h0002_00FF;
  localparam logic [31:0] RST_PLL = 32'h0005_C22E;
  localparam logic [31:0] RST_FRQ = 32'h0000_0000;
  localparam logic [31:0] RST_APB1 = 32'h0000_0000;
  localparam logic [31:0] RST_SEL3 = 32'h0000_003F;
  localparam logic [31:0] RST_DIV1 = 32'h0000_0000;
  localparam logic [31:0] RST_LSKEEP = 32'h0000_0000;

  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 8;            // 125 MHz
  localparam int SWITCH_GAP_NS = 64;           // least clock-off gap on a switch
  localparam int WAKE_SETTLE_NS = 4000;        // least oscillator settle time
  localparam int SWITCH_CYC = (SWITCH_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WAKE_CYC = (WAKE_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // power sequencer states, gray along run, down, settle
  typedef enum logic [1:0] {
    PD_RUN = 2'h0,
    PD_DOWN = 2'h1,
    PD_SETTLE = 2'h3
  } ccpc_pd_state_t;

  // system clock switch states, gray along idle, gap, apply
  typedef enum logic [1:0] {
    SW_IDLE = 2'h0,
    SW_GAP = 2'h1,
    SW_APPLY = 2'h3
  } ccpc_sw_state_t;

endpackage

// >>> ccpc_top.sv
// ccpc_top: chip clock and power controller behind an APB register bank.
// assumes all inputs are synchronous to REF_CLK; the analogue sources, clock
// muxes and gates outside follow the registered enables and selects given here.
`timescale 1ns/100ps
module ccpc_top #(
  parameter int WAKE_CYCLES = ccpc_pkg::WAKE_CYC,   // oscillator settle count
  parameter int SWITCH_CYCLES = ccpc_pkg::SWITCH_CYC // clock-off gap count
) (
  input wire logic REF_CLK,
  input wire logic RSTN,
  input wire logic CLK_EN,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic CPU_SLEEPING,
  input wire logic WAKE_EVENT,
  input wire logic TICK_USE_EXTERNAL,
  output logic HXT_EN,
  output logic LXT_EN,
  output logic HIRC_EN,
  output logic LIRC_EN,
  output logic PLL_EN,
  output logic PLL_REF_SEL,
  output logic [2:0] SYS_CLK_SEL,
  output logic SYS_CLK_GATE,
  output logic [2:0] TICK_CLK_SEL,
  output logic TICK_EXT_GATE,
  output logic [31:0] AHB_CLK_GATE,
  output logic [31:0] APB_CLK_GATE,
  output logic [31:0] APB_CLK_GATE_1,
  output logic [31:0] PERIPH_SEL_1,
  output logic [31:0] PERIPH_SEL_2,
  output logic [31:0] PERIPH_SEL_3,
  output logic [31:0] SYS_DIV,
  output logic [31:0] PERIPH_DIV_1,
  output logic [31:0] PLL_SETTING,
  output logic [31:0] FRQ_DIV_SETTING,
  output logic POWER_DOWN,
  output logic WAKE_IRQ
);

  // ****************************************
  // declarations
  // ****************************************
  localparam int CNT_W = 16;                       // settle / gap counter width
  logic [ccpc_pkg::PWR_W-1:0] pwr_reg;             // power_down_control
  logic [31:0] ahb_reg;                            // ahb_clock_enable
  logic [31:0] apb_reg;                            // apb_clock_enable
  logic [31:0] apb1_reg;                           // apb_clock_enable_1
  logic [31:0] sel0_reg;                           // clock_select_0
  logic [31:0] sel1_reg;                           // clock_select_1
  logic [31:0] sel2_reg;                           // clock_select_2
  logic [31:0] sel3_reg;                           // clock_select_3
  logic [31:0] div_reg;                            // clock_divider
  logic [31:0] div1_reg;                           // clock_divider_1
  logic [31:0] pll_reg;                            // pll_control
  logic [31:0] frq_reg;                            // frequency_divider_control
  logic [31:0] lskeep_reg;                         // peripherals on low-speed sources
  ccpc_pkg::ccpc_pd_state_t pd_reg;                // power sequencer state
  ccpc_pkg::ccpc_pd_state_t pd_next;
  ccpc_pkg::ccpc_sw_state_t sw_reg;                // system clock switch state
  ccpc_pkg::ccpc_sw_state_t sw_next;
  logic [CNT_W-1:0] pd_cnt_reg;                    // wake settle counter
  logic [CNT_W-1:0] sw_cnt_reg;                    // switch gap counter
  logic [2:0] sys_sel_reg;                         // applied system clock source
  logic wr_acc;                                    // write access phase
  logic setup;                                     // setup phase
  logic addr_ok;                                   // address decodes
  logic [31:0] rd_mux;                             // read data of the setup address
  logic wake;                                      // wake-up seen while down
  logic enter_pd;                                  // entry condition met
  logic [2:0] sys_req;                             // software-requested source
  logic is_down;                                   // clocks stopped

  // field pick from a 32-bit word
  function automatic logic [2:0] pick3(input logic [31:0] w, input int lsb);
    pick3 = w[lsb +: 3];
  endfunction

  // ****************************************
  // bus decode
  // ****************************************
  assign setup = PSEL && !PENABLE;
  assign wr_acc = PSEL && PENABLE && PREADY && PWRITE && !PSLVERR;
  assign sys_req = pick3(sel0_reg, ccpc_pkg::SYS_SEL_LSB);
  assign is_down = (pd_reg != ccpc_pkg::PD_RUN);
  assign wake = WAKE_EVENT && (pd_reg == ccpc_pkg::PD_DOWN);

  // entry: with wait bit need wfi sleep, without it go at once
  always_comb begin
    enter_pd = 1'b0;
    if (pwr_reg[ccpc_pkg::B_PD_EN]) begin
      if (pwr_reg[ccpc_pkg::B_WAIT_CPU]) begin
        enter_pd = CPU_SLEEPING;
      end else begin
        enter_pd = 1'b1;
      end
    end
  end

  // read mux and address check
  always_comb begin
    addr_ok = 1'b1;
    rd_mux = 32'h0000_0000;
    case (PADDR)
      ccpc_pkg::OFS_PWR: rd_mux = {{(32 - ccpc_pkg::PWR_W){1'b0}}, pwr_reg};
      ccpc_pkg::OFS_AHB: rd_mux = ahb_reg;
      ccpc_pkg::OFS_APB: rd_mux = apb_reg;
      ccpc_pkg::OFS_STAT: begin
        // live oscillator enables and switch activity
        rd_mux[ccpc_pkg::B_HXT_EN] = HXT_EN;
        rd_mux[ccpc_pkg::B_LXT_EN] = LXT_EN;
        rd_mux[ccpc_pkg::B_HIRC_EN] = HIRC_EN;
        rd_mux[ccpc_pkg::B_LIRC_EN] = LIRC_EN;
        rd_mux[ccpc_pkg::B_WU_DLY] = PLL_EN;
        rd_mux[ccpc_pkg::B_STAT_BUSY] = (sw_reg != ccpc_pkg::SW_IDLE);
      end
      ccpc_pkg::OFS_SEL0: rd_mux = sel0_reg;
      ccpc_pkg::OFS_SEL1: rd_mux = sel1_reg;
      ccpc_pkg::OFS_DIV: rd_mux = div_reg;
      ccpc_pkg::OFS_SEL2: rd_mux = sel2_reg;
      ccpc_pkg::OFS_PLL: rd_mux = pll_reg;
      ccpc_pkg::OFS_FRQ: rd_mux = frq_reg;
      ccpc_pkg::OFS_APB1: rd_mux = apb1_reg;
      ccpc_pkg::OFS_SEL3: rd_mux = sel3_reg;
      ccpc_pkg::OFS_DIV1: rd_mux = div1_reg;
      ccpc_pkg::OFS_LSKEEP: rd_mux = lskeep_reg;
      default: addr_ok = 1'b0;
    endcase
  end

  // ****************************************
  // apb answer: ready in the first access cycle
  // ****************************************
  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
      PRDATA <= 32'h0000_0000;
    end else if (CLK_EN) begin
      PREADY <= setup;
      PSLVERR <= setup && !addr_ok;
      if (setup && !PWRITE) begin
        // status and power_down_control are the only words hardware changes, so the only ones where sample time matters
        PRDATA <= addr_ok ? rd_mux : 32'h0000_0000;
      end
    end
  end

  // ****************************************
  // power_down_control
  // ****************************************
  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      pwr_reg <= ccpc_pkg::RST_PWR[ccpc_pkg::PWR_W-1:0];
    end else if (CLK_EN) begin
      if (wr_acc && PADDR == ccpc_pkg::OFS_PWR) begin
        pwr_reg[ccpc_pkg::B_WAIT_CPU] <= PWDATA[ccpc_pkg::B_WAIT_CPU];
        pwr_reg[ccpc_pkg::B_PD_EN] <= PWDATA[ccpc_pkg::B_PD_EN];
        pwr_reg[ccpc_pkg::B_WU_IE] <= PWDATA[ccpc_pkg::B_WU_IE];
        pwr_reg[ccpc_pkg::B_WU_DLY:0] <= PWDATA[ccpc_pkg::B_WU_DLY:0];
        if (PWDATA[ccpc_pkg::B_WU_STS]) begin
          pwr_reg[ccpc_pkg::B_WU_STS] <= 1'b0;
        end
      end
      // hardware set wins over a write-one clear in the same cycle
      if (wake) begin
        pwr_reg[ccpc_pkg::B_WU_STS] <= 1'b1;
        pwr_reg[ccpc_pkg::B_PD_EN] <= 1'b0;
      end
    end
  end

  // ****************************************
  // clock enable, select and divider registers
  // ****************************************
  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      ahb_reg <= ccpc_pkg::RST_AHB;
      apb_reg <= ccpc_pkg::RST_APB;
      apb1_reg <= ccpc_pkg::RST_APB1;
      sel0_reg <= ccpc_pkg::RST_SEL0;
      sel1_reg <= ccpc_pkg::RST_SEL1;
      sel2_reg <= ccpc_pkg::RST_SEL2;
      sel3_reg <= ccpc_pkg::RST_SEL3;
      div_reg <= ccpc_pkg::RST_DIV;
      div1_reg <= ccpc_pkg::RST_DIV1;
      pll_reg <= ccpc_pkg::RST_PLL;
      frq_reg <= ccpc_pkg::RST_FRQ;
      lskeep_reg <= ccpc_pkg::RST_LSKEEP;
    end else if (CLK_EN && wr_acc) begin
      // plain storage; the sequencers below act on the values
      case (PADDR)
        ccpc_pkg::OFS_AHB: ahb_reg <= PWDATA;
        ccpc_pkg::OFS_APB: apb_reg <= PWDATA;
        ccpc_pkg::OFS_APB1: apb1_reg <= PWDATA;
        ccpc_pkg::OFS_SEL0: sel0_reg <= PWDATA;
        ccpc_pkg::OFS_SEL1: sel1_reg <= PWDATA;
        ccpc_pkg::OFS_SEL2: sel2_reg <= PWDATA;
        ccpc_pkg::OFS_SEL3: sel3_reg <= PWDATA;
        ccpc_pkg::OFS_DIV: div_reg <= PWDATA;
        ccpc_pkg::OFS_DIV1: div1_reg <= PWDATA;
        ccpc_pkg::OFS_PLL: pll_reg <= PWDATA;
        ccpc_pkg::OFS_FRQ: frq_reg <= PWDATA;
        ccpc_pkg::OFS_LSKEEP: lskeep_reg <= PWDATA;
        default: ; // status and power words handled elsewhere
      endcase
    end
  end

  // ****************************************
  // power-down sequencer
  // ****************************************
  always_comb begin
    pd_next = pd_reg;
    case (pd_reg)
      ccpc_pkg::PD_RUN: begin
        if (enter_pd) begin
          pd_next = ccpc_pkg::PD_DOWN;
        end
      end
      ccpc_pkg::PD_DOWN: begin
        // only a wake-up event leaves power-down
        if (wake) begin
          pd_next = pwr_reg[ccpc_pkg::B_WU_DLY] ? ccpc_pkg::PD_SETTLE : ccpc_pkg::PD_RUN;
        end
      end
      ccpc_pkg::PD_SETTLE: begin
        // oscillators restarted, hold clocks off until they settle
        if (pd_cnt_reg == CNT_W'(WAKE_CYCLES - 1)) begin
          pd_next = ccpc_pkg::PD_RUN;
        end
      end
      default: pd_next = ccpc_pkg::PD_RUN;
    endcase
  end

  // state and settle counter
  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      pd_reg <= ccpc_pkg::PD_RUN;
      pd_cnt_reg <= '0;
    end else if (CLK_EN) begin
      pd_reg <= pd_next;
      if (pd_reg == ccpc_pkg::PD_SETTLE) begin
        pd_cnt_reg <= pd_cnt_reg + CNT_W'(1);
      end else begin
        pd_cnt_reg <= '0;
      end
    end
  end

  // ****************************************
  // glitch-free system clock switch
  // ****************************************
  // the gate drops first, the select moves only while the clock is held off
  // for the gap, so the downstream mux never sees a runt pulse
  always_comb begin
    sw_next = sw_reg;
    case (sw_reg)
      ccpc_pkg::SW_IDLE: begin
        if (sys_req != sys_sel_reg) begin
          sw_next = ccpc_pkg::SW_GAP;
        end
      end
      ccpc_pkg::SW_GAP: begin
        if (sw_cnt_reg == CNT_W'(SWITCH_CYCLES - 1)) begin
          sw_next = ccpc_pkg::SW_APPLY;
        end
      end
      ccpc_pkg::SW_APPLY: sw_next = ccpc_pkg::SW_IDLE;
      default: sw_next = ccpc_pkg::SW_IDLE;
    endcase
  end

  // switch state, gap counter and applied select
  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      sw_reg <= ccpc_pkg::SW_IDLE;
      sw_cnt_reg <= '0;
      sys_sel_reg <= pick3(ccpc_pkg::RST_SEL0, ccpc_pkg::SYS_SEL_LSB);
    end else if (CLK_EN) begin
      sw_reg <= sw_next;
      sw_cnt_reg <= (sw_reg == ccpc_pkg::SW_GAP) ? sw_cnt_reg + CNT_W'(1) : '0;
      if (sw_next == ccpc_pkg::SW_APPLY) begin
        sys_sel_reg <= sys_req;
      end
    end
  end

  // ****************************************
  // source enables
  // ****************************************
  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      HXT_EN <= ccpc_pkg::RST_PWR[ccpc_pkg::B_HXT_EN];
      LXT_EN <= ccpc_pkg::RST_PWR[ccpc_pkg::B_LXT_EN];
      HIRC_EN <= ccpc_pkg::RST_PWR[ccpc_pkg::B_HIRC_EN];
      LIRC_EN <= ccpc_pkg::RST_PWR[ccpc_pkg::B_LIRC_EN];
      PLL_EN <= !ccpc_pkg::RST_PLL[ccpc_pkg::B_PLL_OFF];
      PLL_REF_SEL <= ccpc_pkg::RST_PLL[ccpc_pkg::B_PLL_REF];
    end else if (CLK_EN) begin
      // high-speed sources and pll stop while down
      HXT_EN <= pwr_reg[ccpc_pkg::B_HXT_EN] && pd_next != ccpc_pkg::PD_DOWN;
      HIRC_EN <= pwr_reg[ccpc_pkg::B_HIRC_EN] && pd_next != ccpc_pkg::PD_DOWN;
      PLL_EN <= !pll_reg[ccpc_pkg::B_PLL_OFF] && pd_next != ccpc_pkg::PD_DOWN;
      // low-speed sources ignore power-down
      LXT_EN <= pwr_reg[ccpc_pkg::B_LXT_EN];
      LIRC_EN <= pwr_reg[ccpc_pkg::B_LIRC_EN];
      PLL_REF_SEL <= pll_reg[ccpc_pkg::B_PLL_REF];
    end
  end

  // ****************************************
  // system and tick clock routing
  // ****************************************
  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      SYS_CLK_SEL <= pick3(ccpc_pkg::RST_SEL0, ccpc_pkg::SYS_SEL_LSB);
      SYS_CLK_GATE <= 1'b1;
      TICK_CLK_SEL <= pick3(ccpc_pkg::RST_SEL0, ccpc_pkg::TICK_SEL_LSB);
      TICK_EXT_GATE <= 1'b0;
      SYS_DIV <= ccpc_pkg::RST_DIV;
    end else if (CLK_EN) begin
      SYS_CLK_SEL <= sys_sel_reg;
      // off during a switch gap and whenever the chip is down
      SYS_CLK_GATE <= (sw_reg == ccpc_pkg::SW_IDLE) && pd_next == ccpc_pkg::PD_RUN;
      TICK_CLK_SEL <= pick3(sel0_reg, ccpc_pkg::TICK_SEL_LSB);
      TICK_EXT_GATE <= TICK_USE_EXTERNAL && pd_next == ccpc_pkg::PD_RUN;
      SYS_DIV <= div_reg;
    end
  end

  // ****************************************
  // peripheral clock routing and gating
  // ****************************************
  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      AHB_CLK_GATE <= ccpc_pkg::RST_AHB;
      APB_CLK_GATE <= ccpc_pkg::RST_APB;
      APB_CLK_GATE_1 <= ccpc_pkg::RST_APB1;
      PERIPH_SEL_1 <= ccpc_pkg::RST_SEL1;
      PERIPH_SEL_2 <= ccpc_pkg::RST_SEL2;
      PERIPH_SEL_3 <= ccpc_pkg::RST_SEL3;
      PERIPH_DIV_1 <= ccpc_pkg::RST_DIV1;
      PLL_SETTING <= ccpc_pkg::RST_PLL;
      FRQ_DIV_SETTING <= ccpc_pkg::RST_FRQ;
    end else if (CLK_EN) begin
      if (pd_next != ccpc_pkg::PD_RUN) begin
        // down: only apb_clock_enable peripherals marked as low-speed-sourced keep a clock
        AHB_CLK_GATE <= 32'h0000_0000;
        APB_CLK_GATE <= apb_reg & lskeep_reg;
        APB_CLK_GATE_1 <= 32'h0000_0000;
      end else begin
        AHB_CLK_GATE <= ahb_reg;
        APB_CLK_GATE <= apb_reg;
        APB_CLK_GATE_1 <= apb1_reg;
      end
      PERIPH_SEL_1 <= sel1_reg;
      PERIPH_SEL_2 <= sel2_reg;
      PERIPH_SEL_3 <= sel3_reg;
      PERIPH_DIV_1 <= div1_reg;
      PLL_SETTING <= pll_reg;
      FRQ_DIV_SETTING <= frq_reg;
    end
  end

  // ****************************************
  // power state and wake-up interrupt
  // ****************************************
  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      POWER_DOWN <= 1'b0;
      WAKE_IRQ <= 1'b0;
    end else if (CLK_EN) begin
      POWER_DOWN <= is_down;
      WAKE_IRQ <= pwr_reg[ccpc_pkg::B_WU_STS] && pwr_reg[ccpc_pkg::B_WU_IE];
    end
  end

endmodule // ccpc_top

// >>> tb_top.sv
// tb_top: register and power-down sequences for the clock controller.
// assumes shortened settle and switch counts; CLK_EN held high.
`timescale 1ns/100ps
module tb_top;
  // ****************************************
  // signals and tables
  // ****************************************
  logic ref_clk, rstn, psel, penable, pwrite, tick_ext, wfi, wake, er, cpu_sleep, wake_ev;
  logic [7:0] paddr;
  logic [31:0] pwdata, rd, prdata, apb_gate, sel1, sys_div, pll_set;
  logic [2:0] sys_sel, tick_sel;
  logic pready, pslverr, hxt, lxt, hirc, lirc, pll_en, pll_ref, sys_gate, tick_gate, pd, irq;
  int fails, n_tests, k;
  localparam logic [7:0] OFS_T [6] = '{ccpc_pkg::OFS_PWR, ccpc_pkg::OFS_AHB,
    ccpc_pkg::OFS_SEL0, ccpc_pkg::OFS_SEL1, ccpc_pkg::OFS_SEL2, ccpc_pkg::OFS_PLL};
  localparam logic [31:0] RST_T [6] = '{ccpc_pkg::RST_PWR, ccpc_pkg::RST_AHB,
    ccpc_pkg::RST_SEL0, ccpc_pkg::RST_SEL1, ccpc_pkg::RST_SEL2, ccpc_pkg::RST_PLL};
  // design with short counts, core stand-in
  ccpc_top #(.WAKE_CYCLES(4), .SWITCH_CYCLES(2)) dut_u (.REF_CLK(ref_clk), .RSTN(rstn),
    .CLK_EN(1'b1), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
    .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .CPU_SLEEPING(cpu_sleep), .WAKE_EVENT(wake_ev), .TICK_USE_EXTERNAL(tick_ext),
    .HXT_EN(hxt), .LXT_EN(lxt), .HIRC_EN(hirc), .LIRC_EN(lirc), .PLL_EN(pll_en),
    .PLL_REF_SEL(pll_ref), .SYS_CLK_SEL(sys_sel), .SYS_CLK_GATE(sys_gate),
    .TICK_CLK_SEL(tick_sel), .TICK_EXT_GATE(tick_gate), .AHB_CLK_GATE(),
    .APB_CLK_GATE(apb_gate), .APB_CLK_GATE_1(), .PERIPH_SEL_1(sel1), .PERIPH_SEL_2(),
    .PERIPH_SEL_3(), .SYS_DIV(sys_div), .PERIPH_DIV_1(), .PLL_SETTING(pll_set),
    .FRQ_DIV_SETTING(), .POWER_DOWN(pd), .WAKE_IRQ(irq));
  ccpc_core_model core_u (.clk(ref_clk), .rst_n(rstn), .wfi(wfi), .wake(wake),
    .sleeping(cpu_sleep), .wake_event(wake_ev));
  // ****************************************
  // tasks
  // ****************************************
  task automatic give_verdict();
    $display("counts: %0d compares, %0d mismatches", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic timeout();
    fails++;
    give_verdict();
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // one apb transfer; read data and error taken at the ready edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    for (k = 0; k < 16; k++) begin
      @(posedge ref_clk);
      if (pready === 1'b1) break;
    end
    if (k == 16) timeout();
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // bounded wait for the power-down flag
  task automatic wait_pd(input logic v, input int n);
    for (k = 0; k < n && pd !== v; k++) @(posedge ref_clk);
    if (k == n) timeout();
  endtask
  // ****************************************
  // clock and sequence
  // ****************************************
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  initial begin
    {rstn, psel, penable, pwrite, tick_ext, wfi, wake, paddr, pwdata} = '0;
    fails = 0;
    n_tests = 0;
    repeat (10) @(posedge ref_clk);
    rstn <= 1'b1;
    // reset values and an unmapped place
    for (int i = 0; i < 6; i++) begin
      apb(1'b0, OFS_T[i], 32'h0);
      chk("reset value", rd, RST_T[i]);
    end
    apb(1'b1, 8'h40, 32'hFFFF_FFFF);
    chk("unmapped error", 32'(er), 32'h1);
    $display("test reset done");
    // system and tick sources 0 to 4, then routing, division and pll reference
    for (int i = 0; i < 5; i++) begin
      apb(1'b1, ccpc_pkg::OFS_SEL0, 32'(i * 9));
      for (k = 0; k < 32 && !(sys_sel === 3'(i) && sys_gate === 1'b1); k++) @(posedge ref_clk);
      if (k == 32) timeout();
      chk("sys_clk_sel", 32'(sys_sel), 32'(i));
      chk("tick_clk_sel", 32'(tick_sel), 32'(i));
    end
    apb(1'b1, ccpc_pkg::OFS_SEL1, 32'h1234_5678);
    apb(1'b1, ccpc_pkg::OFS_DIV, 32'h0000_00A5);
    apb(1'b1, ccpc_pkg::OFS_PLL, 32'h000C_C22E);
    tick_ext <= 1'b1;
    repeat (3) @(posedge ref_clk);
    chk("periph_sel_1", sel1, 32'h1234_5678);
    chk("sys_div", sys_div, 32'h0000_00A5);
    chk("pll_ref_sel", 32'(pll_ref), 32'h1);
    chk("pll_en", 32'(pll_en), 32'h1);
    chk("pll_set", pll_set, 32'h000C_C22E);
    chk("tick_ext_gate", 32'(tick_gate), 32'h1);
    $display("test select done");
    // immediate power-down, low-speed keep, wake and status clear
    apb(1'b1, ccpc_pkg::OFS_LSKEEP, 32'h0000_0002);
    apb(1'b1, ccpc_pkg::OFS_APB, 32'h0000_0003);
    apb(1'b1, ccpc_pkg::OFS_PWR, 32'h0000_00AF);
    wait_pd(1'b1, 32);
    chk("hxt and hirc", {hxt, hirc}, 32'h0);
    chk("lxt and lirc", {lxt, lirc}, 32'h3);
    chk("apb gates", apb_gate, 32'h0000_0002);
    chk("sys and tick gate", {sys_gate, tick_gate}, 32'h0);
    chk("irq in down", 32'(irq), 32'h0);
    wake <= 1'b1;
    @(posedge ref_clk);
    wake <= 1'b0;
    wait_pd(1'b0, 32);
    apb(1'b0, ccpc_pkg::OFS_PWR, 32'h0);
    chk("pwr after wake", rd, 32'h0000_006F);
    chk("irq after wake", 32'(irq), 32'h1);
    apb(1'b1, ccpc_pkg::OFS_PWR, 32'h0000_006F);
    apb(1'b0, ccpc_pkg::OFS_PWR, 32'h0);
    chk("pwr after clear", rd, 32'h0000_002F);
    chk("irq after clear", 32'(irq), 32'h0);
    $display("test immediate down done");
    // power-down held off until the core sleeps, settle on wake
    apb(1'b1, ccpc_pkg::OFS_PWR, 32'h0000_01BF);
    repeat (20) @(posedge ref_clk);
    chk("down before wfi", 32'(pd), 32'h0);
    wfi <= 1'b1;
    @(posedge ref_clk);
    wfi <= 1'b0;
    wait_pd(1'b1, 32);
    chk("hxt after wfi", 32'(hxt), 32'h0);
    wake <= 1'b1;
    @(posedge ref_clk);
    wake <= 1'b0;
    wait_pd(1'b0, 64);
    apb(1'b0, ccpc_pkg::OFS_PWR, 32'h0);
    chk("pwr after settle", rd, 32'h0000_017F);
    $display("test wfi power-down done");
    give_verdict();
  end
endmodule // tb_top
